/* perf_pair_pkg.sv */
// Purpose: Constants and types for the two-counter performance monitor
// Assumes: 32-bit control register, 40-bit counters
// Notes:   Register selects are plain codes on the model-register port
`default_nettype none
package perf_pair_pkg;

	// ------------------------------------------------------------
	// Register selects
	// ------------------------------------------------------------
	localparam logic [1:0] SEL_CONTROL = 2'h0;
	localparam logic [1:0] SEL_COUNT_ZERO = 2'h1;
	localparam logic [1:0] SEL_COUNT_ONE = 2'h2;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int COUNT_WIDTH = 40;
	localparam int EVENT_WIDTH = 6;
	localparam int EVENT_LSB_ZERO = 0;
	localparam int EVENT_LSB_ONE = 16;
	localparam int CTRL_LSB_ZERO = 6;
	localparam int CTRL_LSB_ONE = 22;
	localparam int PIN_BIT_ZERO = 9;
	localparam int PIN_BIT_ONE = 25;
	localparam int CTRL_DURATION_BIT = 2;
	localparam int CTRL_USER_BIT = 1;
	localparam int CTRL_SYSTEM_BIT = 0;
	localparam logic [1:0] PRIV_USER = 2'h3;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [39:0] COUNT_RESET = 40'h00_0000_0000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int OVERFLOW_LAG_CLOCKS = 5;

	// ------------------------------------------------------------
	// Per-counter settings
	// ------------------------------------------------------------
	typedef struct packed {
		logic [5:0] event_code;
		logic [2:0] count_control;
		logic       pin_function;
	} counter_setup_type;

	// Per-counter event input from the core
	typedef struct packed {
		logic [1:0] occurrences;
		logic       condition;
	} event_input_type;

endpackage
`default_nettype wire

/* perf_event_counter_pair.sv */
// Purpose: Two 40-bit performance counters with monitor pins
// Assumes: Core supplies privilege level and per-counter event inputs
// Notes:   Event decode lives in the core; block counts what it is given
//
// Operation
// - Two independent 40-bit event or clock counters
// - Register access only at privilege level zero
// - Event codes at bits 0-5, 16-21
// - Count-control fields at bits 6-8, 22-24
// - Control bits: duration, level three, levels 0-2
// - Pin flag: 1 overflow, 0 increment
// - Counters readable while running
// - Reset clears the control register
// - Pin pulses per occurrence, holds for duration
// - Pin shows increment, not its size
// - One pin period may span several clocks
// - Overflow on carry out of bit 39
// - Overflow pin asserts five clocks later
// - Pins default to counter indication after reset
`default_nettype none
module perf_event_counter_pair
	import perf_pair_pkg::*;
(
	// Clock and reset
	input  wire logic                    CLK,
	input  wire logic                    RST,
	// Model-register access
	input  wire logic                    REG_READ,
	input  wire logic                    REG_WRITE,
	input  wire logic [1:0]              REG_SELECT,
	input  wire logic [39:0]             REG_WDATA,
	output var  logic [39:0]             REG_RDATA,
	output var  logic                    REG_FAULT,
	// Core state
	input  wire logic [1:0]              CURRENT_PRIVILEGE_LEVEL,
	input  wire event_input_type [1:0]   EVENT_IN,
	// Debugger pin takeover
	input  wire logic                    BREAKPOINT_MODE,
	input  wire logic [1:0]              BREAKPOINT_MATCH,
	// Pins and selected event codes
	output var  logic                    MONITOR_PIN_ZERO,
	output var  logic                    MONITOR_PIN_ONE,
	output var  logic [11:0]             EVENT_SELECT
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [31:0]             counter_control_select;
	logic [31:0]             next_counter_control_select;
	logic [39:0]             count [2];
	logic [39:0]             next_count [2];
	logic [39:0]             reg_rdata;
	logic [39:0]             next_reg_rdata;
	logic                    reg_fault;
	logic                    next_reg_fault;
	logic [4:0]              overflow_pipe [2];
	logic [4:0]              next_overflow_pipe [2];
	logic [1:0]              pin;
	logic [1:0]              next_pin;
	logic [11:0]             event_select;
	logic [11:0]             next_event_select;
	logic                    bp_mode_meta;
	logic                    bp_mode;
	logic [1:0]              bp_match_meta;
	logic [1:0]              bp_match;
	counter_setup_type [1:0] setup;
	logic [1:0]              enabled;
	logic [1:0]              increment;
	logic [1:0]              overflow;
	logic                    access_ok;

	assign access_ok = (CURRENT_PRIVILEGE_LEVEL == 2'h0);

	// ------------------------------------------------------------
	// Field extraction
	// ------------------------------------------------------------
	always_comb begin
		setup[0].event_code    = counter_control_select[EVENT_LSB_ZERO +: EVENT_WIDTH];
		setup[1].event_code    = counter_control_select[EVENT_LSB_ONE +: EVENT_WIDTH];
		setup[0].count_control = counter_control_select[CTRL_LSB_ZERO +: 3];
		setup[1].count_control = counter_control_select[CTRL_LSB_ONE +: 3];
		setup[0].pin_function  = counter_control_select[PIN_BIT_ZERO];
		setup[1].pin_function  = counter_control_select[PIN_BIT_ONE];
	end

	// ------------------------------------------------------------
	// Per-counter counting
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_counter
			logic        duration;
			logic        step_valid;
			logic [39:0] step;
			logic [40:0] sum;

			// Privilege gating from the control field
			always_comb begin
				if (CURRENT_PRIVILEGE_LEVEL == PRIV_USER) begin
					enabled[i] = setup[i].count_control[CTRL_USER_BIT];
				end else begin
					enabled[i] = setup[i].count_control[CTRL_SYSTEM_BIT];
				end
			end

			assign duration = setup[i].count_control[CTRL_DURATION_BIT];

			// Step is one clock for duration, or 1 to 3 events
			always_comb begin
				step       = 40'h00_0000_0000;
				step_valid = 1'b0;
				if (enabled[i]) begin
					if (duration) begin
						step_valid = EVENT_IN[i].condition;
						step       = {39'h0, EVENT_IN[i].condition};
					end else begin
						step_valid = (EVENT_IN[i].occurrences != 2'h0);
						step       = {38'h0, EVENT_IN[i].occurrences};
					end
				end
			end

			assign sum          = {1'b0, count[i]} + {1'b0, step};
			assign increment[i] = step_valid;
			assign overflow[i]  = step_valid & sum[COUNT_WIDTH];

			// Counter update with register write precedence
			always_comb begin
				next_count[i] = sum[39:0];
				if (REG_WRITE && access_ok && REG_SELECT == 2'(i + 1)) begin
					next_count[i] = REG_WDATA;
				end
			end

			// Overflow lag line
			always_comb begin
				next_overflow_pipe[i] = {overflow_pipe[i][3:0], overflow[i]};
			end

			// Monitor pin source
			always_comb begin
				if (bp_mode) begin
					next_pin[i] = bp_match[i];
				end else if (setup[i].pin_function) begin
					next_pin[i] = overflow_pipe[i][OVERFLOW_LAG_CLOCKS - 1];
				end else begin
					next_pin[i] = increment[i];
				end
			end

			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					count[i]         <= COUNT_RESET;
					overflow_pipe[i] <= 5'h00;
					pin[i]           <= 1'b0;
				end else begin
					count[i]         <= next_count[i];
					overflow_pipe[i] <= next_overflow_pipe[i];
					pin[i]           <= next_pin[i];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------
	always_comb begin
		next_counter_control_select = counter_control_select;
		next_reg_rdata              = reg_rdata;
		next_reg_fault              = 1'b0;
		next_event_select           = {setup[1].event_code, setup[0].event_code};
		if ((REG_READ || REG_WRITE) && !access_ok) begin
			next_reg_fault = 1'b1;
		end else if (REG_WRITE && REG_SELECT == SEL_CONTROL) begin
			next_counter_control_select = REG_WDATA[31:0];
		end else if (REG_WRITE && REG_SELECT == SEL_COUNT_ZERO) begin
			next_reg_fault = 1'b0;
		end else if (REG_WRITE && REG_SELECT == SEL_COUNT_ONE) begin
			next_reg_fault = 1'b0;
		end else if (REG_WRITE) begin
			next_reg_fault = 1'b1;
		end else if (REG_READ && REG_SELECT == SEL_CONTROL) begin
			next_reg_rdata = {8'h00, counter_control_select};
		end else if (REG_READ && REG_SELECT == SEL_COUNT_ZERO) begin
			next_reg_rdata = count[0];
		end else if (REG_READ && REG_SELECT == SEL_COUNT_ONE) begin
			next_reg_rdata = count[1];
		end else if (REG_READ) begin
			next_reg_rdata = 40'h00_0000_0000;
			next_reg_fault = 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			counter_control_select <= CONTROL_RESET;
			reg_rdata              <= 40'h00_0000_0000;
			reg_fault              <= 1'b0;
			event_select           <= 12'h000;
		end else begin
			counter_control_select <= next_counter_control_select;
			reg_rdata              <= next_reg_rdata;
			reg_fault              <= next_reg_fault;
			event_select           <= next_event_select;
		end
	end

	// ------------------------------------------------------------
	// Debugger pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bp_mode_meta  <= 1'b0;
			bp_mode       <= 1'b0;
			bp_match_meta <= 2'h0;
			bp_match      <= 2'h0;
		end else begin
			bp_mode_meta  <= BREAKPOINT_MODE;
			bp_mode       <= bp_mode_meta;
			bp_match_meta <= BREAKPOINT_MATCH;
			bp_match      <= bp_match_meta;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign REG_RDATA        = reg_rdata;
	assign REG_FAULT        = reg_fault;
	assign MONITOR_PIN_ZERO = pin[0];
	assign MONITOR_PIN_ONE  = pin[1];
	assign EVENT_SELECT     = event_select;

endmodule
`default_nettype wire

/* perf_pair_checker.sv */
// Purpose: Port checks for the counter pair
// Assumes: Control is mirrored from accepted writes
// Notes:   Bound to the top module
`default_nettype none
module perf_pair_checker
	import perf_pair_pkg::*;
(
	// Clock, reset, access
	input wire logic                  CLK,
	input wire logic                  RST,
	input wire logic                  REG_READ,
	input wire logic                  REG_WRITE,
	input wire logic [1:0]            REG_SELECT,
	input wire logic [39:0]           REG_WDATA,
	input wire logic [39:0]           REG_RDATA,
	input wire logic                  REG_FAULT,
	// Core state and pins
	input wire logic [1:0]            CURRENT_PRIVILEGE_LEVEL,
	input wire event_input_type [1:0] EVENT_IN,
	input wire logic                  BREAKPOINT_MODE,
	input wire logic [1:0]            BREAKPOINT_MATCH,
	input wire logic                  MONITOR_PIN_ZERO,
	input wire logic                  MONITOR_PIN_ONE,
	input wire logic [11:0]           EVENT_SELECT
);
	logic [31:0] ctl;
	logic [11:0] code;
	logic        acc, ok, inc0, inc1;
	logic [1:0]  priv;
	assign priv = CURRENT_PRIVILEGE_LEVEL;
	assign acc = REG_READ || REG_WRITE;
	assign ok = acc && priv == 2'h0;
	assign code = {ctl[21:16], ctl[5:0]};
	assign inc0 = (priv == PRIV_USER ? ctl[7] : ctl[6]) &&
		(ctl[8] ? EVENT_IN[0].condition : EVENT_IN[0].occurrences != 2'h0);
	assign inc1 = (priv == PRIV_USER ? ctl[23] : ctl[22]) &&
		(ctl[24] ? EVENT_IN[1].condition : EVENT_IN[1].occurrences != 2'h0);
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			ctl <= 32'h0;
		else if (ok && REG_WRITE && REG_SELECT == SEL_CONTROL)
			ctl <= REG_WDATA[31:0];
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	property p_fault_refused; acc && priv != 2'h0 |=> REG_FAULT; endproperty
	a_fault_refused: assert property (p_fault_refused) else $error("no fault");
	property p_fault_quiet; !acc || (ok && REG_SELECT != 2'h3) |=> !REG_FAULT; endproperty
	a_fault_quiet: assert property (p_fault_quiet) else $error("spurious fault");
	property p_unmapped; ok && REG_READ && !REG_WRITE && REG_SELECT == 2'h3 |=> REG_RDATA == 40'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped data");
	property p_ctl_read; ok && REG_READ && !REG_WRITE && REG_SELECT == SEL_CONTROL |=> REG_RDATA == {8'h0, ctl}; endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("control read");
	property p_codes; 1'b1 |-> EVENT_SELECT == $past(code); endproperty
	a_codes: assert property (p_codes) else $error("event select");
	property p_bp; (BREAKPOINT_MODE && $stable(BREAKPOINT_MATCH))[*5] |-> {MONITOR_PIN_ONE, MONITOR_PIN_ZERO} == BREAKPOINT_MATCH; endproperty
	a_bp: assert property (p_bp) else $error("breakpoint pins");
	property p_inc0; !BREAKPOINT_MODE[*5] ##0 (!REG_WRITE && !ctl[9]) |=> MONITOR_PIN_ZERO == $past(inc0); endproperty
	a_inc0: assert property (p_inc0) else $error("pin zero");
	property p_inc1; !BREAKPOINT_MODE[*5] ##0 (!REG_WRITE && !ctl[25]) |=> MONITOR_PIN_ONE == $past(inc1); endproperty
	a_inc1: assert property (p_inc1) else $error("pin one");
endmodule
bind perf_event_counter_pair perf_pair_checker i_checker (.CLK(CLK), .RST(RST), .REG_READ(REG_READ),
	.REG_WRITE(REG_WRITE), .REG_SELECT(REG_SELECT), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.REG_FAULT(REG_FAULT), .CURRENT_PRIVILEGE_LEVEL(CURRENT_PRIVILEGE_LEVEL), .EVENT_IN(EVENT_IN),
	.BREAKPOINT_MODE(BREAKPOINT_MODE), .BREAKPOINT_MATCH(BREAKPOINT_MATCH),
	.MONITOR_PIN_ZERO(MONITOR_PIN_ZERO), .MONITOR_PIN_ONE(MONITOR_PIN_ONE), .EVENT_SELECT(EVENT_SELECT));
`default_nettype wire

/* pin_watch_model.sv */
// Purpose: External observer of the monitor pins
// Assumes: Pins sampled on the core clock
// Notes:   Counts high cycles per pin
`default_nettype none
module pin_watch_model (
	// Observed pins
	input wire logic CLK,
	input wire logic RST,
	input wire logic MONITOR_PIN_ZERO,
	input wire logic MONITOR_PIN_ONE,
	// Tallies
	output var int   pulses_zero,
	output var int   pulses_one
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pulses_zero <= 0;
			pulses_one <= 0;
		end else begin
			pulses_zero <= pulses_zero + int'(MONITOR_PIN_ZERO);
			pulses_one <= pulses_one + int'(MONITOR_PIN_ONE);
		end
	end
endmodule
`default_nettype wire

/* test_perf_event_counter_pair.sv */
// Purpose: Self-checking bench for the counter pair
// Assumes: Access answers one edge after it is taken
// Notes:   Reset check, then register rows, then hand-written cases
`default_nettype none
module test_perf_event_counter_pair import perf_pair_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [1:0] p; logic [1:0] s; logic [39:0] d; logic [39:0] e; logic f;} row_type;
	row_type rows [6] = '{'{2'h0, 2'h1, 40'hAB_1234_5678, 40'hAB_1234_5678, 1'b0},
		'{2'h0, 2'h2, 40'h80_8000_0000, 40'h80_8000_0000, 1'b0}, '{2'h0, 2'h0, 40'hFF_0000_0000, 40'h0, 1'b0},
		'{2'h3, 2'h1, 40'h1, 40'hAB_1234_5678, 1'b1}, '{2'h1, 2'h0, 40'h3FF, 40'h0, 1'b1},
		'{2'h0, 2'h3, 40'h5, 40'h0, 1'b1}};
	logic                  clk, rst, rd, wr, bp_mode, fault, pin0, pin1;
	logic [1:0]            sel, priv, bp_match;
	logic [39:0]           wdata, rdata, exp;
	logic [31:0]           ctl;
	logic [11:0]           evsel;
	event_input_type [1:0] ev;
	int                    pulses0, pulses1, fails, check_count, n;
	perf_event_counter_pair i_dut (.CLK(clk), .RST(rst), .REG_READ(rd), .REG_WRITE(wr), .REG_SELECT(sel),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .REG_FAULT(fault), .CURRENT_PRIVILEGE_LEVEL(priv),
		.EVENT_IN(ev), .BREAKPOINT_MODE(bp_mode), .BREAKPOINT_MATCH(bp_match),
		.MONITOR_PIN_ZERO(pin0), .MONITOR_PIN_ONE(pin1), .EVENT_SELECT(evsel));
	pin_watch_model i_pins (.CLK(clk), .RST(rst), .MONITOR_PIN_ZERO(pin0), .MONITOR_PIN_ONE(pin1),
		.pulses_zero(pulses0), .pulses_one(pulses1));
	task automatic chk(input string what, input logic [39:0] e, input logic [39:0] got);
		check_count++;
		if (got !== e) begin
			$display("[ERR] %s expected %h seen %h", what, e, got);
			fails++;
		end
	endtask
	task automatic acc(input logic w, input logic [1:0] s, input logic [39:0] d, input logic [1:0] p);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		sel <= s;
		wdata <= d;
		priv <= p;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		priv <= 2'h0;
		#1;
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#100_000;
		fails++;
		finish_test();
	end
	initial begin
		{rst, rd, wr, bp_mode, sel, priv, bp_match, wdata, ev} = {1'b1, 55'h0};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		acc(1'b0, SEL_CONTROL, 40'h0, 2'h0);
		chk("control after reset", 40'h0, rdata);
		chk("pins after reset", 40'h0, {38'h0, pin1, pin0});
		$display("test reset done");
		foreach (rows[i]) begin
			acc(1'b1, rows[i].s, rows[i].d, rows[i].p);
			chk("write fault", 40'(rows[i].f), 40'(fault));
			acc(1'b0, rows[i].s, 40'h0, 2'h0);
			chk("read back", rows[i].e, rdata);
		end
		$display("test registers done");
		acc(1'b1, SEL_COUNT_ZERO, 40'hFF_FFFF_FFFF, 2'h0);
		acc(1'b1, SEL_CONTROL, 40'h2EA, 2'h0);
		@(posedge clk);
		ev[0].occurrences <= 2'h2;
		@(posedge clk);
		ev[0].occurrences <= 2'h0;
		#1;
		chk("event select", 40'h02A, 40'(evsel));
		n = 0;
		while (pin0 !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("overflow lag", 40'(OVERFLOW_LAG_CLOCKS), 40'(n));
		@(posedge clk);
		#1;
		chk("overflow pulse", 40'h0, 40'(pin0));
		acc(1'b0, SEL_COUNT_ZERO, 40'h0, 2'h0);
		chk("wrapped count", 40'h1, rdata);
		chk("pulses", 40'h1, 40'(pulses0));
		$display("test overflow done");
		for (int c = 0; c < 16; c++) begin
			acc(1'b0, SEL_CONTROL, 40'h0, 2'h0);
			ctl = rdata[31:0] & 32'hFC3F_FFFF;
			acc(1'b1, SEL_CONTROL, {8'h0, ctl}, 2'h0);
			acc(1'b1, SEL_COUNT_ONE, 40'h0, 2'h0);
			acc(1'b1, SEL_CONTROL, {8'h0, ctl | (32'(c[2:0]) << 22)}, 2'h0);
			@(posedge clk);
			ev[1] <= 3'b101;
			priv <= c[3] ? 2'h3 : 2'h0;
			repeat (3) @(posedge clk);
			ev[1] <= 3'b000;
			priv <= 2'h0;
			exp = (c[3] ? c[1] : c[0]) ? (c[2] ? 40'h3 : 40'h6) : 40'h0;
			acc(1'b0, SEL_COUNT_ONE, 40'h0, 2'h0);
			chk("count one", exp, rdata);
		end
		$display("test privilege done");
		@(posedge clk);
		bp_match <= 2'h2;
		bp_mode <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		chk("breakpoint pins", 40'h2, {38'h0, pin1, pin0});
		$display("test breakpoint done");
		finish_test();
	end
endmodule
`default_nettype wire
